// >>> src/periodic_timer_and_watchdog.sv
/*
 * periodic timer and watchdog unit: prescaler, auto-reload timer,
 * watchdog with two service methods, register locks, axi4-lite slave.
 * assumes power mode levels come from logic on i_sys_clk and that the
 * slow clock pin is far slower than i_sys_clk.
 */
`timescale 1ns/1ps

module periodic_timer_and_watchdog (
	input  wire logic                                   i_sys_clk,
	input  wire logic                                   i_rst,
	input  wire logic                                   i_slow_clock,
	input  wire logic                                   i_power_save,
	input  wire logic                                   i_idle,
	input  wire logic                                   i_halt,
	input  wire periodic_timer_and_watchdog_pkg::axi_req_t i_axi,
	output periodic_timer_and_watchdog_pkg::axi_rsp_t   o_axi,
	output logic                                        o_timer_irq,
	output logic                                        o_wakeup_edge,
	output logic                                        o_watchdog_reset
);

	// ==========================================================
	// decoding
	// ==========================================================
	function automatic periodic_timer_and_watchdog_pkg::reg_sel_t
		decode(input logic [31:0] addr);
		unique case (addr)
		{periodic_timer_and_watchdog_pkg::IDX_CFG[29:0], 2'b00}:
			decode = periodic_timer_and_watchdog_pkg::SEL_CFG;
		{periodic_timer_and_watchdog_pkg::IDX_PRESCALE[29:0], 2'b00}:
			decode = periodic_timer_and_watchdog_pkg::SEL_PRESCALE;
		{periodic_timer_and_watchdog_pkg::IDX_PRESET[29:0], 2'b00}:
			decode = periodic_timer_and_watchdog_pkg::SEL_PRESET;
		{periodic_timer_and_watchdog_pkg::IDX_CSR[29:0], 2'b00}:
			decode = periodic_timer_and_watchdog_pkg::SEL_CSR;
		{periodic_timer_and_watchdog_pkg::IDX_WDCOUNT[29:0], 2'b00}:
			decode = periodic_timer_and_watchdog_pkg::SEL_WDCOUNT;
		{periodic_timer_and_watchdog_pkg::IDX_MATCH[29:0], 2'b00}:
			decode = periodic_timer_and_watchdog_pkg::SEL_MATCH;
		default:
			decode = periodic_timer_and_watchdog_pkg::SEL_NONE;
		endcase
	endfunction

	// ==========================================================
	// declarations
	// ==========================================================
	logic        slow_meta_reg;
	logic        slow_sync_reg;
	logic        slow_prev_reg;
	logic        running;
	logic        active;
	logic        slow_edge;
	logic [4:0]  pre_cnt_reg;
	logic [4:0]  pre_last;
	logic        tick;
	logic [5:0]  cfg_reg;
	logic [2:0]  prescale_reg;
	logic [15:0] preset_reg;
	logic [15:0] tmr_cnt_reg;
	logic        pulse_reg;
	logic        pulse_rise;
	logic        restart_reg;
	logic        tc_reg;
	logic        inte_reg;
	logic [7:0]  wd_value_reg;
	logic [7:0]  wd_cnt_reg;
	logic        wd_started_reg;
	logic        wd_stepped_reg;
	logic        wd_edge;
	logic        wd_service;
	logic        wd_error;
	logic        match_en;
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [31:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic        do_write;
	logic        do_read;
	logic        wr_cfg;
	logic        wr_prescale;
	logic        wr_preset;
	logic        wr_csr;
	logic        wr_wdcount;
	logic        wr_match;
	logic [7:0]  wr_byte;
	logic [31:0] rd_value;
	periodic_timer_and_watchdog_pkg::reg_sel_t wr_sel;
	periodic_timer_and_watchdog_pkg::reg_sel_t rd_sel;

	// ==========================================================
	// slow clock synchroniser and prescaler
	// ==========================================================
	assign running = !i_halt;
	// save and idle keep counting; only bus access is narrowed
	assign active  = !(i_power_save || i_idle || i_halt);

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			slow_meta_reg <= 1'b0;
			slow_sync_reg <= 1'b0;
		end else begin
			slow_meta_reg <= i_slow_clock;
			slow_sync_reg <= slow_meta_reg;
		end
	end

	// edge memory is frozen in halt so no edge is lost or invented
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			slow_prev_reg <= 1'b0;
		end else if (running) begin
			slow_prev_reg <= slow_sync_reg;
		end
	end

	assign slow_edge = running && slow_sync_reg && !slow_prev_reg;
	assign pre_last  = 5'((6'h01 << prescale_reg) - 6'h01);
	// reserved divisor codes stop the tick altogether
	assign tick = slow_edge && (pre_cnt_reg == pre_last) &&
		(prescale_reg <= periodic_timer_and_watchdog_pkg::PRESCALE_MAX);

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			pre_cnt_reg <= 5'h00;
		end else if (slow_edge) begin
			if (pre_cnt_reg >= pre_last) begin
				pre_cnt_reg <= 5'h00;
			end else begin
				pre_cnt_reg <= pre_cnt_reg + 5'h01;
			end
		end
	end

	// ==========================================================
	// periodic timer
	// ==========================================================
	assign pulse_rise = tick && !restart_reg && (tmr_cnt_reg == 16'h0001);

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			tmr_cnt_reg <= periodic_timer_and_watchdog_pkg::PRESET_RESET;
			pulse_reg   <= 1'b0;
		end else if (tick) begin
			pulse_reg <= pulse_rise;
			if (restart_reg || tmr_cnt_reg == 16'h0000) begin
				tmr_cnt_reg <= preset_reg;
			end else begin
				tmr_cnt_reg <= tmr_cnt_reg - 16'h0001;
			end
		end
	end

	assign o_timer_irq   = pulse_reg && inte_reg;
	assign o_wakeup_edge = pulse_reg;

	// ==========================================================
	// bus write decode
	// ==========================================================
	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_sel   = decode(aw_addr_reg);
	assign wr_byte  = w_data_reg[7:0];
	// locked or asleep: the write is answered but has no effect; match register writes are shut only by halt
	assign wr_cfg = do_write && active && w_strb_reg[0] &&
		wr_sel == periodic_timer_and_watchdog_pkg::SEL_CFG &&
		!cfg_reg[periodic_timer_and_watchdog_pkg::CFG_LOCK_CFG];
	assign wr_prescale = do_write && active && w_strb_reg[0] &&
		wr_sel == periodic_timer_and_watchdog_pkg::SEL_PRESCALE &&
		!cfg_reg[periodic_timer_and_watchdog_pkg::CFG_LOCK_PRESCALE];
	assign wr_preset = do_write && active &&
		wr_sel == periodic_timer_and_watchdog_pkg::SEL_PRESET &&
		!cfg_reg[periodic_timer_and_watchdog_pkg::CFG_LOCK_PRESET];
	assign wr_csr = do_write && active && w_strb_reg[0] &&
		wr_sel == periodic_timer_and_watchdog_pkg::SEL_CSR &&
		!cfg_reg[periodic_timer_and_watchdog_pkg::CFG_LOCK_PRESET];
	assign wr_wdcount = do_write && active && w_strb_reg[0] &&
		wr_sel == periodic_timer_and_watchdog_pkg::SEL_WDCOUNT &&
		!cfg_reg[periodic_timer_and_watchdog_pkg::CFG_LOCK_WDCOUNT];
	// halt freezes the whole unit, so even the match register is shut
	assign wr_match = do_write && running && w_strb_reg[0] &&
		wr_sel == periodic_timer_and_watchdog_pkg::SEL_MATCH;

	// ==========================================================
	// configuration registers
	// ==========================================================
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cfg_reg <= periodic_timer_and_watchdog_pkg::CFG_RESET;
		end else if (wr_cfg) begin
			// lock bits can only be added, never removed
			cfg_reg <= {wr_byte[5:4], cfg_reg[3:0] | wr_byte[3:0]};
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			prescale_reg <= periodic_timer_and_watchdog_pkg::PRESCALE_RESET;
		end else if (wr_prescale) begin
			prescale_reg <= wr_byte[2:0];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			preset_reg <= periodic_timer_and_watchdog_pkg::PRESET_RESET;
		end else if (wr_preset) begin
			if (w_strb_reg[0]) begin
				preset_reg[7:0] <= w_data_reg[7:0];
			end
			if (w_strb_reg[1]) begin
				preset_reg[15:8] <= w_data_reg[15:8];
			end
		end
	end

	// ==========================================================
	// timer control and status
	// ==========================================================
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			restart_reg <= 1'b0;
		end else if (wr_csr &&
			wr_byte[periodic_timer_and_watchdog_pkg::CSR_RESTART]) begin
			restart_reg <= 1'b1;
		end else if (tick) begin
			restart_reg <= 1'b0;
		end
	end

	// a terminal count in the clearing cycle still sets the flag
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			tc_reg <= 1'b0;
		end else if (pulse_rise) begin
			tc_reg <= 1'b1;
		end else if (wr_csr &&
			wr_byte[periodic_timer_and_watchdog_pkg::CSR_TC]) begin
			tc_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			inte_reg <= 1'b0;
		end else if (wr_csr) begin
			inte_reg <= wr_byte[periodic_timer_and_watchdog_pkg::CSR_INTE];
		end
	end

	// ==========================================================
	// watchdog
	// ==========================================================
	assign match_en = cfg_reg[periodic_timer_and_watchdog_pkg::CFG_MATCH_EN];
	assign wd_edge = (cfg_reg[periodic_timer_and_watchdog_pkg::CFG_CLK_SEL] ==
		periodic_timer_and_watchdog_pkg::CLK_SEL_TICK) ?
		tick : pulse_rise;
	assign wd_service = (wr_wdcount && !match_en) ||
		(wr_match && match_en &&
		wr_byte == periodic_timer_and_watchdog_pkg::SERVICE_KEY);
	assign wd_error =
		(wr_match && match_en &&
		wr_byte != periodic_timer_and_watchdog_pkg::SERVICE_KEY) ||
		(wd_service && wd_started_reg && !wd_stepped_reg) ||
		(wd_started_reg && wd_edge && !wd_service &&
		wd_cnt_reg <= 8'h01);

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			wd_value_reg <= periodic_timer_and_watchdog_pkg::WDCOUNT_RESET;
		end else if (wr_wdcount) begin
			wd_value_reg <= wr_byte;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			wd_started_reg <= 1'b0;
		end else if (wr_wdcount || wr_match) begin
			wd_started_reg <= 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			wd_cnt_reg <= periodic_timer_and_watchdog_pkg::WDCOUNT_RESET;
		end else if (wr_wdcount && (!match_en || !wd_started_reg)) begin
			wd_cnt_reg <= wr_byte;
		end else if (wd_service || (wr_match && !wd_started_reg)) begin
			wd_cnt_reg <= wd_value_reg;
		end else if (wd_started_reg && wd_edge && wd_cnt_reg != 8'h00) begin
			wd_cnt_reg <= wd_cnt_reg - 8'h01;
		end
	end

	// a service counts as too frequent until one watchdog step passed
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			wd_stepped_reg <= 1'b1;
		end else if (wd_service) begin
			wd_stepped_reg <= 1'b0;
		end else if (wd_edge) begin
			wd_stepped_reg <= 1'b1;
		end
	end

	// held until the device reset it requests takes effect
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_watchdog_reset <= 1'b0;
		end else if (wd_error) begin
			o_watchdog_reset <= 1'b1;
		end
	end

	// ==========================================================
	// axi4-lite write channel
	// ==========================================================
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 32'h0000_0000;
		end else if (i_axi.awvalid && !aw_held_reg) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= i_axi.awaddr;
		end else if (do_write) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (i_axi.wvalid && !w_held_reg) begin
			w_held_reg <= 1'b1;
			w_data_reg <= i_axi.wdata;
			w_strb_reg <= i_axi.wstrb;
		end else if (do_write) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= periodic_timer_and_watchdog_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= (wr_sel == periodic_timer_and_watchdog_pkg::SEL_NONE) ?
				periodic_timer_and_watchdog_pkg::RESP_SLVERR :
				periodic_timer_and_watchdog_pkg::RESP_OKAY;
		end else if (i_axi.bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ==========================================================
	// axi4-lite read channel
	// ==========================================================
	assign do_read = i_axi.arvalid && !rvalid_reg;
	assign rd_sel  = decode(i_axi.araddr);

	// locked, asleep and write-only registers all read as zero
	always_comb begin
		rd_value = 32'h0000_0000;
		if (active) begin
			unique case (rd_sel)
			periodic_timer_and_watchdog_pkg::SEL_CFG:
				if (!cfg_reg[periodic_timer_and_watchdog_pkg::CFG_LOCK_CFG]) begin
					rd_value = {26'h0, cfg_reg};
				end
			periodic_timer_and_watchdog_pkg::SEL_PRESCALE:
				if (!cfg_reg[periodic_timer_and_watchdog_pkg::CFG_LOCK_PRESCALE])
					begin
					rd_value = {29'h0, prescale_reg};
				end
			periodic_timer_and_watchdog_pkg::SEL_PRESET:
				if (!cfg_reg[periodic_timer_and_watchdog_pkg::CFG_LOCK_PRESET])
					begin
					rd_value = {16'h0, preset_reg};
				end
			periodic_timer_and_watchdog_pkg::SEL_CSR:
				if (!cfg_reg[periodic_timer_and_watchdog_pkg::CFG_LOCK_PRESET])
					begin
					rd_value = {29'h0, inte_reg, tc_reg, restart_reg};
				end
			periodic_timer_and_watchdog_pkg::SEL_WDCOUNT:
				if (!cfg_reg[periodic_timer_and_watchdog_pkg::CFG_LOCK_WDCOUNT])
					begin
					rd_value = {24'h0, wd_value_reg};
				end
			default: rd_value = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= periodic_timer_and_watchdog_pkg::RESP_OKAY;
		end else if (do_read) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_value;
			rresp_reg  <= (rd_sel == periodic_timer_and_watchdog_pkg::SEL_NONE) ?
				periodic_timer_and_watchdog_pkg::RESP_SLVERR :
				periodic_timer_and_watchdog_pkg::RESP_OKAY;
		end else if (i_axi.rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign o_axi.awready = !aw_held_reg;
	assign o_axi.wready  = !w_held_reg;
	assign o_axi.bvalid  = bvalid_reg;
	assign o_axi.bresp   = bresp_reg;
	assign o_axi.arready = !rvalid_reg;
	assign o_axi.rvalid  = rvalid_reg;
	assign o_axi.rdata   = rdata_reg;
	assign o_axi.rresp   = rresp_reg;

	// ==========================================================
	// assertions
	// ==========================================================
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	sequence s_tick_at_zero;
		tick && !restart_reg && tmr_cnt_reg == 16'h0000;
	endsequence
	sequence s_key_service;
		wr_match && match_en && wd_started_reg && wd_stepped_reg &&
		wr_byte == periodic_timer_and_watchdog_pkg::SERVICE_KEY;
	endsequence

	a_tick_on_edge: assert property (tick |-> slow_edge)
		else $error("tick without slow clock edge");
	a_timer_step: assert property (tick && !restart_reg &&
		tmr_cnt_reg != 16'h0000 |=> tmr_cnt_reg == $past(tmr_cnt_reg) - 16'h0001)
		else $error("timer did not decrement");
	a_timer_reload: assert property (s_tick_at_zero |=>
		tmr_cnt_reg == $past(preset_reg))
		else $error("timer did not reload from preset");
	a_pulse_sets_tc: assert property (pulse_rise |=> pulse_reg && tc_reg)
		else $error("terminal count missed pulse or flag");
	a_irq_gating: assert property (pulse_rise && inte_reg &&
		!wr_csr |=> o_timer_irq)
		else $error("enabled timer pulse raised no irq");
	a_restart_clear: assert property (tick && restart_reg |=>
		!restart_reg && tmr_cnt_reg == $past(preset_reg))
		else $error("restart did not reload and clear");
	a_wd_idle_quiet: assert property (!wd_started_reg && !wr_match &&
		!wr_wdcount |-> !wd_error ##1 !o_watchdog_reset)
		else $error("stopped watchdog signalled");
	a_wd_stays_on: assert property (wd_started_reg |=> wd_started_reg)
		else $error("watchdog stopped without reset");
	a_key_reload: assert property (s_key_service |=>
		wd_cnt_reg == $past(wd_value_reg) && !o_watchdog_reset)
		else $error("key service did not reload watchdog");
	a_bad_key_reset: assert property (wr_match && match_en &&
		wr_byte != periodic_timer_and_watchdog_pkg::SERVICE_KEY |=>
		o_watchdog_reset [*3])
		else $error("wrong key did not request reset");
	a_lock_sticky: assert property (|cfg_reg[3:0] |=>
		(cfg_reg[3:0] & $past(cfg_reg[3:0])) == $past(cfg_reg[3:0]))
		else $error("lock bit cleared");
	a_halt_freeze: assert property (i_halt |=>
		$stable(tmr_cnt_reg) && $stable(wd_cnt_reg) && $stable(pre_cnt_reg))
		else $error("counters moved during halt");

endmodule // periodic_timer_and_watchdog

// >>> src/periodic_timer_and_watchdog_pkg.sv
/*
 * constants, register map and bus carriers for the periodic timer and
 * watchdog unit.
 * assumes a 32-bit axi4-lite master and the slow clock as a free pin.
 */

package periodic_timer_and_watchdog_pkg;

	// ==========================================================
	// register indices; byte address is four times the index
	// ==========================================================
	localparam logic [31:0] IDX_CFG      = 32'h00ff_ff20;
	localparam logic [31:0] IDX_PRESCALE = 32'h00ff_ff22;
	localparam logic [31:0] IDX_PRESET   = 32'h00ff_ff24;
	localparam logic [31:0] IDX_CSR      = 32'h00ff_ff26;
	localparam logic [31:0] IDX_WDCOUNT  = 32'h00ff_ff28;
	localparam logic [31:0] IDX_MATCH    = 32'h00ff_ff2a;

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int unsigned CFG_LOCK_CFG      = 0;
	localparam int unsigned CFG_LOCK_PRESCALE = 1;
	localparam int unsigned CFG_LOCK_PRESET   = 2;
	localparam int unsigned CFG_LOCK_WDCOUNT  = 3;
	localparam int unsigned CFG_CLK_SEL       = 4;
	localparam int unsigned CFG_MATCH_EN      = 5;
	localparam int unsigned CSR_RESTART       = 0;
	localparam int unsigned CSR_TC            = 1;
	localparam int unsigned CSR_INTE          = 2;

	// ==========================================================
	// values after reset and fixed codes
	// ==========================================================
	localparam logic [5:0]  CFG_RESET      = 6'h00;
	localparam logic [2:0]  PRESCALE_RESET = 3'h0;
	localparam logic [15:0] PRESET_RESET   = 16'hffff;
	localparam logic [7:0]  WDCOUNT_RESET  = 8'hff;
	localparam logic [7:0]  SERVICE_KEY    = 8'h5c;
	localparam logic [2:0]  PRESCALE_MAX   = 3'h5;
	localparam logic        CLK_SEL_TICK   = 1'b1;
	localparam logic [1:0]  RESP_OKAY      = 2'b00;
	localparam logic [1:0]  RESP_SLVERR    = 2'b10;

	typedef enum logic [2:0] {
		SEL_CFG, SEL_PRESCALE, SEL_PRESET, SEL_CSR, SEL_WDCOUNT,
		SEL_MATCH, SEL_NONE
	} reg_sel_t;

	// ==========================================================
	// axi4-lite carriers
	// ==========================================================
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_t;

endpackage

// >>> verif/testbench.sv
/*
 * self-checking bench for the periodic timer and watchdog unit.
 * assumes the slow clock pin is far slower than i_sys_clk.
 */
`timescale 1ns/1ps

module testbench;
	localparam int SLOW_HALF = 10;
	localparam int TICK = 2 * SLOW_HALF;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_slow_clock = 1'b0;
	logic i_power_save = 1'b0;
	logic i_idle = 1'b0;
	logic i_halt = 1'b0;
	periodic_timer_and_watchdog_pkg::axi_req_t req = '0;
	periodic_timer_and_watchdog_pkg::axi_rsp_t rsp;
	logic o_timer_irq, o_wakeup_edge, o_watchdog_reset;
	logic irq_seen = 1'b0;
	logic [31:0] rdat;
	logic [1:0] resp;
	int slow_cnt = 0;
	int error_cnt = 0;
	int samples_checked = 0;
	int n;

	periodic_timer_and_watchdog u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_slow_clock(i_slow_clock), .i_power_save(i_power_save),
		.i_idle(i_idle), .i_halt(i_halt), .i_axi(req), .o_axi(rsp),
		.o_timer_irq(o_timer_irq), .o_wakeup_edge(o_wakeup_edge),
		.o_watchdog_reset(o_watchdog_reset));

	// ==========================================================
	// clocks and monitors
	// ==========================================================
	always #2.5 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
		if (slow_cnt == SLOW_HALF - 1) i_slow_clock <= ~i_slow_clock;
	end
	always @(negedge i_sys_clk) if (o_timer_irq === 1'b1) irq_seen <= 1'b1;

	// ==========================================================
	// tasks
	// ==========================================================
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask

	// outputs are sampled at the falling edge, where they are settled
	task automatic wr(input logic [31:0] idx, input logic [31:0] d);
		bit ta, tw, hb;
		req.awaddr <= idx << 2;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(negedge i_sys_clk);
			ta = req.awvalid && rsp.awready;
			tw = req.wvalid && rsp.wready;
			hb = rsp.bvalid;
			resp = rsp.bresp;
			@(posedge i_sys_clk);
			if (ta) req.awvalid <= 1'b0;
			if (tw) req.wvalid <= 1'b0;
		end while (!hb);
		req.bready <= 1'b0;
	endtask

	task automatic rchk(input logic [31:0] idx, input logic [31:0] e, input string what);
		bit ta, hr;
		req.araddr <= idx << 2;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(negedge i_sys_clk);
			ta = req.arvalid && rsp.arready;
			hr = rsp.rvalid;
			rdat = rsp.rdata;
			@(posedge i_sys_clk);
			if (ta) req.arvalid <= 1'b0;
		end while (!hr);
		req.rready <= 1'b0;
		chk(what, e, rdat);
	endtask

	task automatic wait_lvl(input bit wd, input logic v, output int c);
		c = 0;
		do begin
			@(negedge i_sys_clk);
			c++;
		end while ((wd ? o_watchdog_reset : o_wakeup_edge) !== v && c < 6000);
		@(posedge i_sys_clk);
	endtask

	// preset is 3 throughout, so a period is four ticks
	task automatic period(input int tk);
		int w;
		// a pulse may still stand from before a prescale change
		wait_lvl(1'b0, 1'b0, w);
		wait_lvl(1'b0, 1'b1, w);
		wait_lvl(1'b0, 1'b0, w);
		chk("pulse width", tk, w);
		wait_lvl(1'b0, 1'b1, n);
		chk("timer period", 4 * tk, w + n);
	endtask

	task automatic do_reset;
		i_rst <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		@(negedge i_sys_clk);
		chk("reset request", 0, o_watchdog_reset);
		@(posedge i_sys_clk);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================================
	// tests
	// ==========================================================
	initial begin
		repeat (40000) @(posedge i_sys_clk);
		error_cnt++;
		end_sim();
	end

	initial begin
		do_reset();
		rchk(periodic_timer_and_watchdog_pkg::IDX_CFG, 0, "cfg");
		rchk(periodic_timer_and_watchdog_pkg::IDX_PRESET, 32'hffff, "preset");
		rchk(periodic_timer_and_watchdog_pkg::IDX_CSR, 0, "csr");
		wr(32'h0, 32'h1);
		chk("unmapped resp", periodic_timer_and_watchdog_pkg::RESP_SLVERR, resp);
		$display("test reset done");
		wr(periodic_timer_and_watchdog_pkg::IDX_PRESET, 3);
		// the running count only sees the new preset after a reload
		wr(periodic_timer_and_watchdog_pkg::IDX_CSR, 32'h1);
		for (int p = 0; p < 6; p++) begin
			wr(periodic_timer_and_watchdog_pkg::IDX_PRESCALE, p);
			period(TICK << p);
		end
		chk("irq while disabled", 0, irq_seen);
		rchk(periodic_timer_and_watchdog_pkg::IDX_CSR, 32'h2, "csr flag");
		wr(periodic_timer_and_watchdog_pkg::IDX_PRESCALE, 0);
		wr(periodic_timer_and_watchdog_pkg::IDX_CSR, 32'h6);
		wait_lvl(1'b0, 1'b1, n);
		chk("irq enabled", 1, irq_seen);
		wait_lvl(1'b0, 1'b0, n);
		wait_lvl(1'b0, 1'b1, n);
		i_halt <= 1'b1;
		repeat (100) @(posedge i_sys_clk);
		chk("halt freeze", 1, o_wakeup_edge);
		i_halt <= 1'b0;
		wait_lvl(1'b0, 1'b0, n);
		chk("halt resume", 1, n <= 2 * TICK);
		$display("test timer done");
		i_power_save <= 1'b1;
		wr(periodic_timer_and_watchdog_pkg::IDX_PRESCALE, 3);
		rchk(periodic_timer_and_watchdog_pkg::IDX_CSR, 0, "save read");
		period(TICK);
		i_power_save <= 1'b0;
		rchk(periodic_timer_and_watchdog_pkg::IDX_PRESCALE, 0, "save write");
		wr(periodic_timer_and_watchdog_pkg::IDX_CFG, 32'h2);
		wr(periodic_timer_and_watchdog_pkg::IDX_PRESCALE, 3);
		wr(periodic_timer_and_watchdog_pkg::IDX_CFG, 32'h0);
		rchk(periodic_timer_and_watchdog_pkg::IDX_CFG, 32'h2, "lock kept");
		i_idle <= 1'b1;
		rchk(periodic_timer_and_watchdog_pkg::IDX_CFG, 0, "idle read");
		i_idle <= 1'b0;
		period(TICK);
		$display("test save and lock done");
		// tick-clocked watchdog serviced by count writes, then left to lapse
		wr(periodic_timer_and_watchdog_pkg::IDX_CFG, 32'h12);
		for (int i = 0; i < 6; i++) begin
			wr(periodic_timer_and_watchdog_pkg::IDX_WDCOUNT, 3);
			repeat (30) @(posedge i_sys_clk);
		end
		chk("count service", 0, o_watchdog_reset);
		wait_lvl(1'b1, 1'b1, n);
		// third tick after the last service, less the 30 cycles already spent
		chk("late error", 1, n > 2 * TICK - 30 && n <= 3 * TICK - 30);
		do_reset();
		rchk(periodic_timer_and_watchdog_pkg::IDX_CFG, 0, "lock cleared");
		$display("test count service done");
		// pulse-clocked watchdog serviced by the key after each pulse
		wr(periodic_timer_and_watchdog_pkg::IDX_PRESET, 3);
		wr(periodic_timer_and_watchdog_pkg::IDX_CSR, 32'h1);
		wr(periodic_timer_and_watchdog_pkg::IDX_CFG, 32'h20);
		wr(periodic_timer_and_watchdog_pkg::IDX_WDCOUNT, 2);
		for (int i = 0; i < 4; i++) begin
			wait_lvl(1'b0, 1'b1, n);
			wr(periodic_timer_and_watchdog_pkg::IDX_MATCH, 32'h5c);
			wait_lvl(1'b0, 1'b0, n);
		end
		chk("key service", 0, o_watchdog_reset);
		wr(periodic_timer_and_watchdog_pkg::IDX_MATCH, 32'h5c);
		wait_lvl(1'b1, 1'b1, n);
		chk("often error", 1, n <= 5);
		do_reset();
		wr(periodic_timer_and_watchdog_pkg::IDX_CFG, 32'h20);
		wr(periodic_timer_and_watchdog_pkg::IDX_MATCH, 32'h11);
		wait_lvl(1'b1, 1'b1, n);
		chk("wrong key error", 1, n <= 5);
		$display("test key service done");
		end_sim();
	end
endmodule // testbench
